// ### include/e4csr_params.svh
// offsets, field positions, reset values and constants of the csr decoder
// assumes word addresses of 16 bits and 32-bit data words
`ifndef E4CSR_PARAMS_SVH
`define E4CSR_PARAMS_SVH

`define E4C_RSVD_VALUE 32'h00000000
`define E4C_PAGE_FIRST 4'h3
`define E4C_PAGE_LAST 4'hB
`define E4C_PAGE_COUNT 9
`define E4C_REL_REVID 8'h00
`define E4C_REL_SCRATCH 8'h01
`define E4C_REL_NAME0 8'h02
`define E4C_REL_NAME2 8'h04
`define E4C_RSV_LO 16'h0100
`define E4C_RSV_HI 16'h02FF
`define E4C_KR_LO 16'h00B0
`define E4C_KR_HI 16'h00BD
`define E4C_KR_FEC_LO 16'h00B8
`define E4C_AN_LO 16'h00C0
`define E4C_AN_HI 16'h00CC
`define E4C_LT_LO 16'h00D0
`define E4C_LT_HI 16'h00EB
`define E4C_KR_INT_BIT 10
`define E4C_PHY_LO 16'h0310
`define E4C_PHY_HI 16'h0344
`define E4C_LF_CFG 16'h0405
`define E4C_GAP_TRIM 16'h0406
`define E4C_TX_MAX 16'h0407
`define E4C_RX_MAX 16'h0506
`define E4C_FCS_FWD 16'h0507
`define E4C_LF_STAT 16'h0508
`define E4C_LEN_CHK 16'h050A
`define E4C_TXP_LO 16'h0605
`define E4C_TXP_HI 16'h060A
`define E4C_RXP_LO 16'h0700
`define E4C_RXP_HI 16'h0703
`define E4C_TXS_LO 16'h0800
`define E4C_TXS_HI 16'h0837
`define E4C_TXS2_LO 16'h0860
`define E4C_TXS2_HI 16'h0861
`define E4C_TXC_CFG 16'h0845
`define E4C_TXC_STAT 16'h0846
`define E4C_RXS_LO 16'h0900
`define E4C_RXS_HI 16'h0937
`define E4C_RXS2_LO 16'h0960
`define E4C_RXS2_HI 16'h0961
`define E4C_RXC_CFG 16'h0945
`define E4C_RXC_STAT 16'h0946
`define E4C_TXT_LO 16'h0A00
`define E4C_TXT_HI 16'h0A0C
`define E4C_RXT_LO 16'h0B00
`define E4C_RXT_HI 16'h0B06
`define E4C_XCVR_PAGE 4'h4
`define E4C_FRAME_MAX_RST 16'h05EE
`define E4C_REVID_VALUE 32'h00000001
`define E4C_NAME0_VALUE 32'h65346331
`define E4C_NAME1_VALUE 32'h65346332
`define E4C_NAME2_VALUE 32'h65346333

`endif

// ### include/e4csr_pkg.sv
// types of the csr decoder: request, forward port, decoder state
// assumes the constants of e4csr_params.svh
package e4csr_pkg;

  typedef enum logic [3:0] {
    E4CSR_CAT_NONE = 4'h0,
    E4CSR_CAT_KR = 4'h1,
    E4CSR_CAT_PHY = 4'h2,
    E4CSR_CAT_TXPAUSE = 4'h3,
    E4CSR_CAT_RXPAUSE = 4'h4,
    E4CSR_CAT_TXSTAT = 4'h5,
    E4CSR_CAT_RXSTAT = 4'h6,
    E4CSR_CAT_TXPTP = 4'h7,
    E4CSR_CAT_RXPTP = 4'h8,
    E4CSR_CAT_XCVR = 4'h9
  } e4csr_cat_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } e4csr_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    e4csr_cat_t cat;
    logic [1:0] lane;
    logic [15:0] addr;
    logic [31:0] wdata;
  } e4csr_fwd_t;

  typedef struct packed {
    logic [8:0][31:0] scratch;
    logic [31:0] lf_cfg;
    logic [31:0] gap_trim;
    logic [15:0] tx_max;
    logic [15:0] rx_max;
    logic [31:0] fcs_fwd;
    logic len_chk_en;
    logic [31:0] txc_cfg;
    logic [31:0] rxc_cfg;
    logic p_rd;
    logic p_fwd;
    logic [31:0] p_rdata;
    e4csr_fwd_t fwd;
    logic [31:0] rdata;
    logic rvalid;
    logic waitreq;
    logic [31:0] tx_too_long_count;
    logic [31:0] rx_too_long_count;
    logic rx_len_err;
  } e4csr_state_t;

endpackage

// ### tb/e4csr_sub_model.sv
// sub-block model that answers reads forwarded by the csr decoder
// assumes read data is taken in the cycle that fwd.rd is high
`timescale 1ns/100ps
module e4csr_sub_model
  import e4csr_pkg::*;
(
  // clock
  input wire logic mclk,
  // forward port
  input wire e4csr_fwd_t fwd,
  output logic [31:0] fwd_rdata
);
  logic [31:0] last_reg = 32'h0;
  logic [31:0] ans;
  // answer names category and word reached, and the lane for xcvr words only
  assign ans = {8'hC0, (fwd.cat == E4CSR_CAT_XCVR) ? {2'h0, fwd.lane} : 4'h0, fwd.cat, fwd.addr};
  always @(posedge mclk) begin
    if (fwd.rd === 1'h1) begin
      last_reg <= ans;
    end
  end
  // not selected: inverse of last answer
  assign fwd_rdata = (fwd.rd === 1'h1) ? ans : ~last_reg;
endmodule

// ### tb/test_e4csr_decoder.sv
// self-checking bench: one decoder with all options, one with most off
// assumes the sub-block model and the decoder's two-cycle read answer
`timescale 1ns/100ps
`include "e4csr_params.svh"
module test_e4csr_decoder
  import e4csr_pkg::*;
;
  localparam logic [31:0] DC = 32'hXXXXXXXX;
  localparam bit OFF = 1'b0;
  localparam logic [1:0] NO_FC = 2'h0;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic ce = 1'h1;
  e4csr_req_t csr_req = '0;
  logic [31:0] lf_status = 32'h0;
  logic [31:0] txc_status = 32'h0;
  logic [31:0] rxc_status = 32'h0;
  logic tx_frame_done = 1'h0;
  logic rx_frame_done = 1'h0;
  logic rx_len_mismatch = 1'h0;
  logic [15:0] tx_frame_len = 16'h0;
  logic [15:0] rx_frame_len = 16'h0;
  e4csr_fwd_t fwd_a, fwd_b;
  logic [31:0] frd_a, frd_b, rdata_a, rdata_b, lfc, gap, fcs, txs, rxs, txc, rxc;
  logic val_a, val_b, lerr, wreq;
  int seed = 9;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] q1[$];
  logic [31:0] q2[$];
  logic [15:0] rsv[6] = '{16'h0100, 16'h01FF, 16'h02FF, 16'h00BE, 16'h00CD, 16'h00EC};
  logic [15:0] fa[15] = '{16'h00B0, 16'h00B8, 16'h00C0, 16'h00D0, 16'h0310, 16'h0605,
    16'h060A, 16'h0805, 16'h0961, 16'h0A05, 16'h0B06, 16'h4000, 16'h4400, 16'h4805, 16'h4C00};
  e4csr_cat_t fc[15] = '{E4CSR_CAT_KR, E4CSR_CAT_KR, E4CSR_CAT_KR, E4CSR_CAT_KR, E4CSR_CAT_PHY,
    E4CSR_CAT_TXPAUSE, E4CSR_CAT_TXPAUSE, E4CSR_CAT_TXSTAT, E4CSR_CAT_RXSTAT, E4CSR_CAT_TXPTP,
    E4CSR_CAT_RXPTP, E4CSR_CAT_XCVR, E4CSR_CAT_XCVR, E4CSR_CAT_XCVR, E4CSR_CAT_XCVR};
  logic [14:0] fon = 15'h7811;
  ////////////////////////////////////////////////////////////////////////////////
  e4csr_decoder DUT (.mclk(mclk), .resetn(resetn), .ce(ce), .csr_req(csr_req),
    .dummy_unused_never(), .csr_rdata(rdata_a), .csr_rdata_valid(val_a), .csr_waitrequest(wreq),
    .fwd(fwd_a), .fwd_rdata(frd_a), .lf_status(lf_status), .txc_status(txc_status),
    .rxc_status(rxc_status), .tx_frame_done(tx_frame_done), .tx_frame_len(tx_frame_len),
    .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len), .rx_len_mismatch(rx_len_mismatch),
    .lf_cfg(lfc), .gap_column_trim(gap), .fcs_forward_setup(fcs), .tx_counter_setup(txs),
    .rx_counter_setup(rxs), .tx_too_long_count(txc), .rx_too_long_count(rxc), .rx_len_error(lerr));
  e4csr_decoder #(.EN_FEC(OFF), .EN_AN(OFF), .EN_LT(OFF), .EN_LF(OFF), .FC_MODE(NO_FC),
    .EN_TXSTAT(OFF), .EN_RXSTAT(OFF), .EN_PTP(OFF)) DUT_OFF (.mclk(mclk), .resetn(resetn),
    .ce(ce), .csr_req(csr_req), .dummy_unused_never(), .csr_rdata(rdata_b),
    .csr_rdata_valid(val_b), .csr_waitrequest(), .fwd(fwd_b), .fwd_rdata(frd_b),
    .lf_status(lf_status), .txc_status(txc_status), .rxc_status(rxc_status),
    .tx_frame_done(tx_frame_done), .tx_frame_len(tx_frame_len), .rx_frame_done(rx_frame_done),
    .rx_frame_len(rx_frame_len), .rx_len_mismatch(rx_len_mismatch), .lf_cfg(),
    .gap_column_trim(), .fcs_forward_setup(), .tx_counter_setup(), .rx_counter_setup(),
    .tx_too_long_count(), .rx_too_long_count(), .rx_len_error());
  e4csr_sub_model SUB_A (.mclk(mclk), .fwd(fwd_a), .fwd_rdata(frd_a));
  e4csr_sub_model SUB_B (.mclk(mclk), .fwd(fwd_b), .fwd_rdata(frd_b));
  initial begin
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] e2);
    @(posedge mclk);
    #10;
    csr_req.wr = 1'h0;
    csr_req.rd = 1'h1;
    csr_req.addr = a;
    q1.push_back(e);
    q2.push_back(e2);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    #10;
    csr_req.rd = 1'h0;
    csr_req.wr = 1'h1;
    csr_req.addr = a;
    csr_req.wdata = d;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      #10;
      csr_req = '0;
    end
  endtask
  task automatic frame(input logic tx, input logic [15:0] len, input logic mm);
    @(posedge mclk);
    #10;
    tx_frame_done = tx;
    rx_frame_done = ~tx;
    tx_frame_len = len;
    rx_frame_len = len;
    rx_len_mismatch = mm;
    @(posedge mclk);
    #10;
    tx_frame_done = 1'h0;
    rx_frame_done = 1'h0;
  endtask
  function automatic logic [31:0] fx(input e4csr_cat_t c, input logic [15:0] a);
    return {8'hC0, (c == E4CSR_CAT_XCVR) ? {2'h0, a[11:10]} : 4'h0, c,
      (a < 16'h0100) ? (a | 16'h0400) : a};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // read answers in issue order
  always @(posedge mclk) begin : mon
    logic [31:0] e;
    if (val_a === 1'h1) begin
      e = (q1.size() > 0) ? q1.pop_front() : DC;
      cmp("read", rdata_a, e);
    end
    if (val_b === 1'h1) begin
      e = (q2.size() > 0) ? q2.pop_front() : DC;
      cmp("read off", rdata_b, e);
    end
  end
  initial begin
    #500000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
  initial begin : main
    logic [31:0] d;
    logic [31:0] v[5];
    logic [15:0] a;
    logic [15:0] len;
    logic mm;
    logic on;
    int tc;
    int rc;
    lf_status = $random(seed);
    txc_status = $random(seed);
    rxc_status = $random(seed);
    repeat (10) @(posedge mclk);
    #10;
    cmp("waitreq in reset", {31'h0, wreq}, 32'h1);
    resetn = 1'h1;
    idle(2);
    cmp("waitreq after reset", {31'h0, wreq}, 32'h0);
    // pages 0x3 to 0x5 exist in every build, the others vanish on the reduced one
    for (int p = 3; p <= 11; p++) begin
      d = $random(seed);
      a = {4'h0, p[3:0], 8'h00};
      on = p <= 5;
      wr(a | 16'h1, d);
      rd(a | 16'h1, d, on ? d : 32'h0);
      wr(a, ~d);
      rd(a, `E4C_REVID_VALUE, on ? `E4C_REVID_VALUE : 32'h0);
      rd(a | 16'h2, `E4C_NAME0_VALUE, on ? `E4C_NAME0_VALUE : 32'h0);
      rd(a | 16'h4, `E4C_NAME2_VALUE, on ? `E4C_NAME2_VALUE : 32'h0);
    end
    $display("test pages done");
    foreach (rsv[i]) begin
      wr(rsv[i], 32'hFFFFFFFF);
      rd(rsv[i], 32'h0, 32'h0);
    end
    $display("test reserved done");
    foreach (v[i]) v[i] = $random(seed);
    wr(`E4C_LF_CFG, v[0]);
    wr(`E4C_GAP_TRIM, v[1]);
    wr(`E4C_FCS_FWD, v[2]);
    wr(`E4C_TXC_CFG, v[3]);
    wr(`E4C_RXC_CFG, v[4]);
    rd(`E4C_LF_CFG, v[0], 32'h0);
    rd(`E4C_GAP_TRIM, v[1], v[1]);
    rd(`E4C_FCS_FWD, v[2], v[2]);
    rd(`E4C_TXC_CFG, v[3], 32'h0);
    rd(`E4C_RXC_CFG, v[4], 32'h0);
    wr(`E4C_TXC_STAT, ~txc_status);
    rd(`E4C_TXC_STAT, txc_status, 32'h0);
    rd(`E4C_RXC_STAT, rxc_status, 32'h0);
    rd(`E4C_LF_STAT, lf_status, 32'h0);
    wr(`E4C_TX_MAX, 32'hFFFF0064);
    wr(`E4C_RX_MAX, 32'h00000064);
    wr(`E4C_LEN_CHK, 32'h00000001);
    rd(`E4C_TX_MAX, 32'h00000064, 32'h00000064);
    rd(`E4C_RX_MAX, 32'h00000064, 32'h00000064);
    rd(`E4C_LEN_CHK, 32'h00000001, 32'h00000001);
    idle(1);
    cmp("lf_cfg", lfc, v[0]);
    cmp("gap", gap, v[1]);
    cmp("fcs", fcs, v[2]);
    cmp("txs", txs, v[3]);
    cmp("rxs", rxs, v[4]);
    $display("test registers done");
    // absent words on the reduced decoder give zero, nothing else relied on
    foreach (fa[i]) begin
      d = fx(fc[i], fa[i]);
      rd(fa[i], d, fon[i] ? d : 32'h0);
    end
    $display("test forward done");
    idle(3);
    tc = 0;
    rc = 0;
    for (int i = 0; i < 16; i++) begin
      len = 16'h0060 + 16'($random(seed) & 7);
      mm = 1'($random(seed));
      frame(i[0], len, mm);
      if (i[0] && len > 16'h0064) tc++;
      if (!i[0] && len > 16'h0064) rc++;
      cmp("rx len err", {31'h0, lerr}, {31'h0, !i[0] && mm});
      cmp("tx count", txc, tc);
      cmp("rx count", rxc, rc);
    end
    wr(`E4C_LEN_CHK, 32'h0);
    idle(1);
    frame(1'h0, 16'h0040, 1'h1);
    cmp("rx len off", {31'h0, lerr}, 32'h0);
    $display("test frames done");
    // oversize frame while disabled leaves the counter alone
    @(posedge mclk);
    #10;
    ce = 1'h0;
    frame(1'h1, 16'h0100, 1'h0);
    cmp("tx count held", txc, tc);
    ce = 1'h1;
    $display("test enable done");
    idle(4);
    cmp("pending", q1.size() + q2.size(), 32'h0);
    end_sim();
  end
endmodule

// ### verilog/e4csr_decoder.sv
// word-addressed csr decoder and local register map of the 40g mac/phy
// assumes a host that holds each request one cycle and sub-blocks that answer
// forwarded reads combinationally in the same cycle as the strobe
`timescale 1ns/100ps
`include "e4csr_params.svh"

module e4csr_decoder
  import e4csr_pkg::*;
#(
  parameter bit EN_KR = 1'b1,
  parameter bit EN_FEC = 1'b1,
  parameter bit EN_AN = 1'b1,
  parameter bit EN_LT = 1'b1,
  parameter bit EN_LF = 1'b1,
  parameter bit EN_GAP = 1'b1,
  parameter logic [1:0] FC_MODE = 2'h1,
  parameter bit EN_TXSTAT = 1'b1,
  parameter bit EN_RXSTAT = 1'b1,
  parameter bit EN_PTP = 1'b1,
  parameter bit EN_XCVR = 1'b1
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // control and status port
  input wire e4csr_req_t csr_req,
  output e4csr_state_t dummy_unused_never,
  output logic [31:0] csr_rdata,
  output logic csr_rdata_valid,
  output logic csr_waitrequest,
  // sub-block forward port
  output e4csr_fwd_t fwd,
  input wire logic [31:0] fwd_rdata,
  // mac status inputs
  input wire logic [31:0] lf_status,
  input wire logic [31:0] txc_status,
  input wire logic [31:0] rxc_status,
  // frame events
  input wire logic tx_frame_done,
  input wire logic [15:0] tx_frame_len,
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_len,
  input wire logic rx_len_mismatch,
  // configuration and event outputs
  output logic [31:0] lf_cfg,
  output logic [31:0] gap_column_trim,
  output logic [31:0] fcs_forward_setup,
  output logic [31:0] tx_counter_setup,
  output logic [31:0] rx_counter_setup,
  output logic [31:0] tx_too_long_count,
  output logic [31:0] rx_too_long_count,
  output logic rx_len_error
);

  e4csr_state_t s;
  e4csr_state_t n;
  logic [8:0] page_on;

  ////////////////////////////////////////////////////////////////////////////
  // page presence per build option

  always_comb begin
    page_on[0] = 1'b1;
    page_on[1] = 1'b1;
    page_on[2] = 1'b1;
    page_on[3] = FC_MODE != 2'h0;
    page_on[4] = FC_MODE != 2'h0;
    page_on[5] = EN_TXSTAT;
    page_on[6] = EN_RXSTAT;
    page_on[7] = EN_PTP;
    page_on[8] = EN_PTP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] a;
    logic take;
    logic wr;
    logic fwd_hit;
    e4csr_cat_t cat;
    logic [31:0] lrd;
    logic [3:0] pidx;
    a = csr_req.addr;
    take = !s.waitreq;
    wr = take && csr_req.wr;
    fwd_hit = 1'b0;
    cat = E4CSR_CAT_NONE;
    lrd = `E4C_RSVD_VALUE;
    pidx = a[11:8] - `E4C_PAGE_FIRST;
    n = s;
    n.waitreq = 1'b0;
    // forwarded ranges; anything unmatched stays reserved
    if (a[15:12] == `E4C_XCVR_PAGE) begin
      fwd_hit = EN_XCVR;
      cat = E4CSR_CAT_XCVR;
    end else if (a[15:12] != 4'h0) begin
      fwd_hit = 1'b0;
    end else if (a >= `E4C_KR_LO && a <= `E4C_KR_HI) begin
      fwd_hit = EN_KR && (EN_FEC || a < `E4C_KR_FEC_LO);
      cat = E4CSR_CAT_KR;
    end else if (a >= `E4C_AN_LO && a <= `E4C_AN_HI) begin
      fwd_hit = EN_KR && EN_AN;
      cat = E4CSR_CAT_KR;
    end else if (a >= `E4C_LT_LO && a <= `E4C_LT_HI) begin
      fwd_hit = EN_KR && EN_LT;
      cat = E4CSR_CAT_KR;
    end else if (a >= `E4C_PHY_LO && a <= `E4C_PHY_HI) begin
      fwd_hit = 1'b1;
      cat = E4CSR_CAT_PHY;
    end else if (a >= `E4C_TXP_LO && a <= `E4C_TXP_HI) begin
      fwd_hit = FC_MODE != 2'h0;
      cat = E4CSR_CAT_TXPAUSE;
    end else if (a >= `E4C_RXP_LO && a <= `E4C_RXP_HI) begin
      fwd_hit = FC_MODE != 2'h0;
      cat = E4CSR_CAT_RXPAUSE;
    end else if ((a >= `E4C_TXS_LO && a <= `E4C_TXS_HI) ||
                 (a >= `E4C_TXS2_LO && a <= `E4C_TXS2_HI)) begin
      fwd_hit = EN_TXSTAT;
      cat = E4CSR_CAT_TXSTAT;
    end else if ((a >= `E4C_RXS_LO && a <= `E4C_RXS_HI) ||
                 (a >= `E4C_RXS2_LO && a <= `E4C_RXS2_HI)) begin
      fwd_hit = EN_RXSTAT;
      cat = E4CSR_CAT_RXSTAT;
    end else if (a >= `E4C_TXT_LO && a <= `E4C_TXT_HI && a[7:0] > `E4C_REL_NAME2) begin
      fwd_hit = EN_PTP;
      cat = E4CSR_CAT_TXPTP;
    end else if (a >= `E4C_RXT_LO && a <= `E4C_RXT_HI && a[7:0] > `E4C_REL_NAME2) begin
      fwd_hit = EN_PTP;
      cat = E4CSR_CAT_RXPTP;
    end
    // per-page revision, scratch and name words
    if (a[15:12] == 4'h0 && a[11:8] >= `E4C_PAGE_FIRST && a[11:8] <= `E4C_PAGE_LAST &&
        a[7:0] <= `E4C_REL_NAME2 && page_on[pidx]) begin
      fwd_hit = 1'b0;
      unique case (a[7:0])
        `E4C_REL_REVID: lrd = `E4C_REVID_VALUE;
        `E4C_REL_SCRATCH: lrd = s.scratch[pidx];
        8'h02: lrd = `E4C_NAME0_VALUE;
        8'h03: lrd = `E4C_NAME1_VALUE;
        default: lrd = `E4C_NAME2_VALUE;
      endcase
      if (wr && a[7:0] == `E4C_REL_SCRATCH) begin
        n.scratch[pidx] = csr_req.wdata;
      end
    end
    // local mac words; read-only and absent words drop writes
    unique case (a)
      `E4C_LF_CFG: if (EN_LF) begin
        lrd = s.lf_cfg;
        if (wr) n.lf_cfg = csr_req.wdata;
      end
      `E4C_GAP_TRIM: if (EN_GAP) begin
        lrd = s.gap_trim;
        if (wr) n.gap_trim = csr_req.wdata;
      end
      `E4C_TX_MAX: begin
        lrd = {16'h0000, s.tx_max};
        if (wr) n.tx_max = csr_req.wdata[15:0];
      end
      `E4C_RX_MAX: begin
        lrd = {16'h0000, s.rx_max};
        if (wr) n.rx_max = csr_req.wdata[15:0];
      end
      `E4C_FCS_FWD: begin
        lrd = s.fcs_fwd;
        if (wr) n.fcs_fwd = csr_req.wdata;
      end
      `E4C_LF_STAT: lrd = EN_LF ? lf_status : 32'h00000000;
      `E4C_LEN_CHK: begin
        lrd = {31'h00000000, s.len_chk_en};
        if (wr) n.len_chk_en = csr_req.wdata[0];
      end
      `E4C_TXC_CFG: if (EN_TXSTAT) begin
        lrd = s.txc_cfg;
        if (wr) n.txc_cfg = csr_req.wdata;
      end
      `E4C_TXC_STAT: if (EN_TXSTAT) lrd = txc_status;
      `E4C_RXC_CFG: if (EN_RXSTAT) begin
        lrd = s.rxc_cfg;
        if (wr) n.rxc_cfg = csr_req.wdata;
      end
      `E4C_RXC_STAT: if (EN_RXSTAT) lrd = rxc_status;
      default: begin
      end
    endcase
    // forward strobe, kr remap and lane select
    n.fwd.rd = take && csr_req.rd && fwd_hit;
    n.fwd.wr = wr && fwd_hit;
    n.fwd.cat = fwd_hit ? cat : E4CSR_CAT_NONE;
    n.fwd.lane = a[11:10];
    n.fwd.addr = a;
    if (cat == E4CSR_CAT_KR) begin
      n.fwd.addr[`E4C_KR_INT_BIT] = 1'b1;
    end
    n.fwd.wdata = csr_req.wdata;
    // fixed two-cycle read answer
    n.p_rd = take && csr_req.rd && !csr_req.wr;
    n.p_fwd = fwd_hit;
    n.p_rdata = lrd;
    n.rvalid = s.p_rd;
    if (s.p_rd) begin
      n.rdata = s.p_fwd ? fwd_rdata : s.p_rdata;
    end
    // oversize counting and length error flag
    if (tx_frame_done && tx_frame_len > s.tx_max) begin
      n.tx_too_long_count = s.tx_too_long_count + 32'h00000001;
    end
    if (rx_frame_done && rx_frame_len > s.rx_max) begin
      n.rx_too_long_count = s.rx_too_long_count + 32'h00000001;
    end
    n.rx_len_err = rx_frame_done && rx_len_mismatch && s.len_chk_en;
    n.fwd.rd = n.fwd.rd && !(take && csr_req.wr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.tx_max <= `E4C_FRAME_MAX_RST;
      s.rx_max <= `E4C_FRAME_MAX_RST;
      s.waitreq <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    dummy_unused_never = s;
    csr_rdata = s.rdata;
    csr_rdata_valid = s.rvalid;
    csr_waitrequest = s.waitreq;
    fwd = s.fwd;
    lf_cfg = s.lf_cfg;
    gap_column_trim = s.gap_trim;
    fcs_forward_setup = s.fcs_fwd;
    tx_counter_setup = s.txc_cfg;
    rx_counter_setup = s.rxc_cfg;
    tx_too_long_count = s.tx_too_long_count;
    rx_too_long_count = s.rx_too_long_count;
    rx_len_error = s.rx_len_err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_read_latency: assert property (
    (ce && csr_req.rd && !csr_req.wr && !s.waitreq) ##1 ce |=> s.rvalid)
    else $error("read not answered in two cycles");

  chk_rsvd_read: assert property (
    (ce && csr_req.rd && !csr_req.wr && !s.waitreq &&
     csr_req.addr >= `E4C_RSV_LO && csr_req.addr <= `E4C_RSV_HI) ##1 ce
    |=> s.rvalid && s.rdata == `E4C_RSVD_VALUE)
    else $error("reserved read not constant");

  chk_rsvd_write: assert property (
    (ce && csr_req.wr && !s.waitreq &&
     csr_req.addr >= `E4C_RSV_LO && csr_req.addr <= `E4C_RSV_HI)
    |=> !s.fwd.wr && $stable(s.scratch) && $stable(s.tx_max))
    else $error("reserved write had an effect");

  chk_scratch_write: assert property (
    (ce && csr_req.wr && !s.waitreq && csr_req.addr == 16'h0301)
    |=> s.scratch[0] == $past(csr_req.wdata))
    else $error("scratch not written");

  chk_ro_status: assert property (
    (ce && csr_req.wr && !s.waitreq && csr_req.addr == `E4C_LF_STAT)
    |=> !s.fwd.wr && $stable(s.lf_cfg) && $stable(s.rx_max))
    else $error("read-only write had an effect");

  chk_kr_remap: assert property (
    (s.fwd.rd || s.fwd.wr) && s.fwd.cat == E4CSR_CAT_KR
    |-> s.fwd.addr[`E4C_KR_INT_BIT] && s.fwd.addr[15:11] == 5'h00)
    else $error("kr address not remapped");

  chk_lane_select: assert property (
    (s.fwd.rd || s.fwd.wr) && s.fwd.cat == E4CSR_CAT_XCVR
    |-> s.fwd.lane == s.fwd.addr[11:10] && s.fwd.addr[15:12] == `E4C_XCVR_PAGE)
    else $error("lane select wrong");

  chk_tx_oversize: assert property (
    ce && tx_frame_done && tx_frame_len > s.tx_max
    |=> s.tx_too_long_count == $past(s.tx_too_long_count) + 32'h00000001)
    else $error("tx oversize not counted");

  chk_len_flag: assert property (
    ce && rx_frame_done && rx_len_mismatch |=> s.rx_len_err == $past(s.len_chk_en))
    else $error("length error flag wrong");

  chk_rx_oversize: assert property (
    ce && rx_frame_done && rx_frame_len > s.rx_max
    |=> s.rx_too_long_count == $past(s.rx_too_long_count) + 32'h00000001)
    else $error("rx oversize not counted");

  chk_fault_zero: assert property (
    (!EN_LF && ce && csr_req.rd && !csr_req.wr && !s.waitreq &&
     csr_req.addr == `E4C_LF_STAT) ##1 ce |=> s.rvalid && s.rdata == 32'h00000000)
    else $error("fault status not zero when absent");

  chk_pause_gate: assert property (
    (s.fwd.rd || s.fwd.wr) && FC_MODE == 2'h0
    |-> s.fwd.cat != E4CSR_CAT_TXPAUSE && s.fwd.cat != E4CSR_CAT_RXPAUSE)
    else $error("pause word reached without flow control");

  chk_ce_freeze: assert property (
    !ce |=> $stable(s))
    else $error("state moved while disabled");

  cov_fwd_read: cover property (s.fwd.rd ##1 s.rvalid);
  cov_fwd_write: cover property (s.fwd.wr);
  cov_ce_hold: cover property (!ce ##1 ce);
  cov_local_write: cover property (ce && csr_req.wr && csr_req.addr == `E4C_TX_MAX);
  cov_oversize: cover property (ce && rx_frame_done && rx_frame_len > s.rx_max);

endmodule
